// file: inc/dlcop_pkg.sv
/*
 * Shared constants for the display list coprocessor: register offsets,
 * field positions, reset values, beam timing and instruction layout.
 * Assumes a 32-bit APB with byte addresses and 16-bit list memory words.
 */
`default_nettype none

package dlcop_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam int PADDR_W = 8;

	// ------------------------------------------------------------
	// APB register offsets
	// ------------------------------------------------------------
	localparam logic [PADDR_W-1:0] OFF_DMA_CONTROL = 8'h00;
	localparam logic [PADDR_W-1:0] OFF_LIST_PTR1   = 8'h04;
	localparam logic [PADDR_W-1:0] OFF_LIST_PTR2   = 8'h08;
	localparam logic [PADDR_W-1:0] OFF_JUMP1       = 8'h0C;
	localparam logic [PADDR_W-1:0] OFF_JUMP2       = 8'h10;
	localparam logic [PADDR_W-1:0] OFF_BEAM_CFG    = 8'h14;
	localparam logic [PADDR_W-1:0] OFF_STATUS      = 8'h18;
	localparam logic [PADDR_W-1:0] OFF_BEAM_POS    = 8'h1C;

	// ------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------
	localparam int DMA_EN_BIT = 7;
	localparam int CFG_PAL_BIT = 0;
	localparam int CFG_LACE_BIT = 1;
	localparam logic [15:0] DMA_CONTROL_RST = 16'h0000;
	localparam logic [ADDR_W-1:0] LIST_PTR_RST = 24'h000000;
	localparam logic [1:0] BEAM_CFG_RST = 2'h0;

	// ------------------------------------------------------------
	// Instruction layout
	// ------------------------------------------------------------
	localparam int IR_TYPE_BIT = 0;
	localparam int IR_BLIT_BIT = 15;
	localparam logic [ADDR_W-1:0] WORD_STEP = 24'h000002;
	localparam logic [ADDR_W-1:0] INSTR_STEP = 24'h000004;
	// Move destinations that act as jump strobes inside the list
	localparam logic [8:0] DA_JUMP1 = 9'h0C8;
	localparam logic [8:0] DA_JUMP2 = 9'h0CA;

	// ------------------------------------------------------------
	// Beam timing
	// ------------------------------------------------------------
	localparam logic [1:0] HPOS_DIV_LAST = 2'h3;
	localparam logic [7:0] HPOS_LAST = 8'hE2;
	localparam logic [9:0] LINES_NTSC = 10'h106;
	localparam logic [9:0] LINES_PAL = 10'h138;
	localparam logic [9:0] LINES_PAL_LONG = 10'h139;

endpackage

`default_nettype wire

// file: hdl/dlcop_cmp.sv
/*
 * Masked greater-or-equal compare of an instruction position against
 * the live beam counters. Purely combinational.
 * Assumes the beam horizontal count never exceeds its last position.
 */
`timescale 1ns/100ps
`default_nettype none

module dlcop_cmp
	import dlcop_pkg::*;
(
	// Instruction words
	input  wire logic [15:0] first_instr_word,
	input  wire logic [15:0] second_instr_word,
	// Live beam
	input  wire logic [7:0]  beam_v,
	input  wire logic [7:0]  beam_h,
	// Result
	output logic             pos_reached
);

	wire logic [14:0] compare_mask;
	wire logic [14:0] beam_val;
	wire logic [14:0] instr_val;

	// Top vertical bit has no enable, it always takes part
	assign compare_mask = {1'b1, second_instr_word[14:1]};
	assign beam_val = {beam_v, beam_h[7:1]} & compare_mask;
	assign instr_val = first_instr_word[15:1] & compare_mask;
	assign pos_reached = beam_val >= instr_val;

endmodule

`default_nettype wire

// file: hdl/dlcop_beam.sv
/*
 * Beam position counters with NTSC/PAL field lengths and interlace (PAL only).
 * Assumes one horizontal step every four clocks; vblank pulses once
 * per field when the vertical count wraps to zero.
 */
`timescale 1ns/100ps
`default_nettype none

module dlcop_beam
	import dlcop_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Mode
	input  wire logic       pal_mode,
	input  wire logic       interlace,
	// Beam
	output logic [9:0]      vpos,
	output logic [7:0]      hpos,
	output logic            vblank_start
);

	logic [1:0] div_q;
	logic       long_q;
	logic [7:0] hpos_q;
	logic [9:0] vpos_q;
	logic       vbl_q;

	wire logic       tick = div_q == HPOS_DIV_LAST;
	wire logic       line_end = tick & (hpos_q == HPOS_LAST);
	wire logic [9:0] field_lines = !pal_mode ? LINES_NTSC :
		(interlace && long_q) ? LINES_PAL_LONG : LINES_PAL;
	wire logic       field_end = line_end & (vpos_q == field_lines - 10'h001);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 2'h0;
			hpos_q <= 8'h00;
			vpos_q <= 10'h000;
			long_q <= 1'b0;
			vbl_q <= 1'b0;
		end else begin
			div_q <= div_q + 2'h1;
			vbl_q <= field_end;
			if (line_end)
				hpos_q <= 8'h00;
			else if (tick)
				hpos_q <= hpos_q + 8'h01;
			if (field_end) begin
				vpos_q <= 10'h000;
				long_q <= interlace & ~long_q;
			end else if (line_end) begin
				vpos_q <= vpos_q + 10'h001;
			end
		end
	end

	assign vpos = vpos_q;
	assign hpos = hpos_q;
	assign vblank_start = vbl_q;

endmodule

`default_nettype wire

// file: hdl/dlcop_top.sv
/*
 * Display list coprocessor: fetches two-word instructions from list
 * memory, waits on or skips over beam positions, and issues register
 * moves. Software reaches its registers over APB.
 * Assumes memory answers a held request with a one-cycle ack and data,
 * and that the move port's consumer takes every one-cycle write.
 */
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module dlcop_top
	import dlcop_pkg::*;
(
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB slave
	input  wire logic [PADDR_W-1:0] paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// List memory read
	output logic                    mem_req,
	output logic      [ADDR_W-1:0]  mem_addr,
	input  wire logic [15:0]        mem_rdata,
	input  wire logic               mem_ack,
	// Register move port
	output logic                    move_valid,
	output logic      [8:0]         move_addr,
	output logic      [15:0]        move_data,
	// Blitter and beam
	input  wire logic               blit_done,
	output logic                    vblank
);

	// ------------------------------------------------------------
	// Types and state
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH1,
		ST_FETCH2,
		ST_DECODE
	} dlcop_state_e;

	function automatic logic [ADDR_W-1:0] dlcop_step(
		input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] step
	);
		dlcop_step = addr + step;
	endfunction

	dlcop_state_e      state_q, state_d;
	logic [15:0]       dma_control_q;
	logic [ADDR_W-1:0] list_pointer_one_q, list_pointer_two_q;
	logic [1:0]        beam_cfg_q;
	logic [ADDR_W-1:0] pc_q, pc_d;
	logic [15:0]       first_instr_word_q, first_instr_word_d;
	logic [15:0]       second_instr_word_q, second_instr_word_d;
	logic              req_q, req_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic              pend_q, pend_d;
	logic [ADDR_W-1:0] pend_addr_q, pend_addr_d;
	logic              mv_q, mv_d;
	logic [8:0]        mv_addr_q;
	logic [15:0]       mv_data_q;
	logic [31:0]       prdata_q;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	wire logic acc = psel & penable;
	wire logic wr = acc & pwrite;
	wire logic sel_dma = paddr == OFF_DMA_CONTROL;
	wire logic sel_lp1 = paddr == OFF_LIST_PTR1;
	wire logic sel_lp2 = paddr == OFF_LIST_PTR2;
	wire logic sel_j1 = paddr == OFF_JUMP1;
	wire logic sel_j2 = paddr == OFF_JUMP2;
	wire logic sel_cfg = paddr == OFF_BEAM_CFG;
	wire logic sel_sts = paddr == OFF_STATUS;
	wire logic sel_pos = paddr == OFF_BEAM_POS;
	wire logic mapped = sel_dma | sel_lp1 | sel_lp2 | sel_j1 | sel_j2 |
		sel_cfg | sel_sts | sel_pos;

	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	// ------------------------------------------------------------
	// Beam and compare
	// ------------------------------------------------------------
	logic [9:0] beam_v;
	logic [7:0] beam_h;
	logic       vbl_pulse;
	logic       pos_reached;

	dlcop_beam u_beam (
		.pclk         (pclk),
		.presetn      (presetn),
		.pal_mode     (beam_cfg_q[CFG_PAL_BIT]),
		.interlace    (beam_cfg_q[CFG_LACE_BIT]),
		.vpos         (beam_v),
		.hpos         (beam_h),
		.vblank_start (vbl_pulse)
	);

	// Compare uses live counters, never a snapshot
	dlcop_cmp u_cmp (
		.first_instr_word  (first_instr_word_q),
		.second_instr_word (second_instr_word_q),
		.beam_v            (beam_v[7:0]),
		.beam_h            (beam_h),
		.pos_reached       (pos_reached)
	);

	// ------------------------------------------------------------
	// Instruction decode and restart
	// ------------------------------------------------------------
	wire logic coproc_dma_enable = dma_control_q[DMA_EN_BIT];
	wire logic is_move = ~first_instr_word_q[IR_TYPE_BIT];
	wire logic is_skip = second_instr_word_q[IR_TYPE_BIT];
	wire logic blit_done_ignore = second_instr_word_q[IR_BLIT_BIT];
	wire logic wait_met = pos_reached &
		(blit_done_ignore | blit_done);
	wire logic [8:0] dest_reg_addr = {first_instr_word_q[8:1], 1'b0};

	// Strobes come from APB access of either direction or from a move
	wire logic jump_one = (acc & sel_j1) |
		(mv_q & (mv_addr_q == DA_JUMP1));
	wire logic jump_two = (acc & sel_j2) |
		(mv_q & (mv_addr_q == DA_JUMP2));
	wire logic restart = jump_one | jump_two | vbl_pulse;
	// Strobe two wins, then strobe one, then the vblank reload
	wire logic [ADDR_W-1:0] restart_addr = jump_two ? list_pointer_two_q :
		list_pointer_one_q;
	wire logic go = restart | pend_q;
	wire logic [ADDR_W-1:0] go_addr = restart ? restart_addr : pend_addr_q;
	// An issued fetch must complete before the counter is re-pointed
	wire logic mem_busy = req_q & ~mem_ack;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		pc_d = pc_q;
		first_instr_word_d = first_instr_word_q;
		second_instr_word_d = second_instr_word_q;
		req_d = req_q;
		addr_d = addr_q;
		pend_d = pend_q;
		pend_addr_d = pend_addr_q;
		mv_d = 1'b0;
		if (req_q && mem_ack)
			req_d = 1'b0;
		if (go && !mem_busy) begin
			pc_d = go_addr;
			state_d = ST_FETCH1;
			pend_d = 1'b0;
		end else if (go) begin
			pend_d = 1'b1;
			pend_addr_d = go_addr;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					state_d = ST_IDLE;
				end
				ST_FETCH1, ST_FETCH2: begin
					// Disabled DMA issues no new fetch; one in flight ends
					if (!req_q && coproc_dma_enable) begin
						req_d = 1'b1;
						addr_d = pc_q;
					end else if (req_q && mem_ack) begin
						pc_d = dlcop_step(pc_q, WORD_STEP);
						if (state_q == ST_FETCH1) begin
							first_instr_word_d = mem_rdata;
							state_d = ST_FETCH2;
						end else begin
							second_instr_word_d = mem_rdata;
							state_d = ST_DECODE;
						end
					end
				end
				ST_DECODE: begin
					if (is_move) begin
						if (coproc_dma_enable) begin
							mv_d = 1'b1;
							state_d = ST_FETCH1;
						end
					end else if (is_skip) begin
						if (pos_reached)
							pc_d = dlcop_step(pc_q, INSTR_STEP);
						state_d = ST_FETCH1;
					end else if (wait_met) begin
						state_d = ST_FETCH1;
					end
					// An unreachable wait stays here until restart
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			pc_q <= LIST_PTR_RST;
			first_instr_word_q <= 16'h0000;
			second_instr_word_q <= 16'h0000;
			req_q <= 1'b0;
			addr_q <= LIST_PTR_RST;
			pend_q <= 1'b0;
			pend_addr_q <= LIST_PTR_RST;
		end else begin
			state_q <= state_d;
			pc_q <= pc_d;
			first_instr_word_q <= first_instr_word_d;
			second_instr_word_q <= second_instr_word_d;
			req_q <= req_d;
			addr_q <= addr_d;
			pend_q <= pend_d;
			pend_addr_q <= pend_addr_d;
		end
	end

	// ------------------------------------------------------------
	// Move port
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mv_q <= 1'b0;
			mv_addr_q <= 9'h000;
			mv_data_q <= 16'h0000;
		end else begin
			mv_q <= mv_d;
			if (mv_d) begin
				mv_addr_q <= dest_reg_addr;
				mv_data_q <= second_instr_word_q;
			end
		end
	end

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_control_q <= DMA_CONTROL_RST;
			list_pointer_one_q <= LIST_PTR_RST;
			list_pointer_two_q <= LIST_PTR_RST;
			beam_cfg_q <= BEAM_CFG_RST;
		end else begin
			if (wr && sel_dma)
				dma_control_q <= pwdata[15:0];
			// Word aligned: bit 0 of a pointer is forced low
			if (wr && sel_lp1)
				list_pointer_one_q <= {pwdata[ADDR_W-1:1], 1'b0};
			if (wr && sel_lp2)
				list_pointer_two_q <= {pwdata[ADDR_W-1:1], 1'b0};
			if (wr && sel_cfg)
				beam_cfg_q <= pwdata[1:0];
		end
	end

	// ------------------------------------------------------------
	// Read data, captured in the setup cycle
	// ------------------------------------------------------------
	wire logic [3:0] status_bits = {pend_q,
		state_q == ST_DECODE, state_q == ST_FETCH1 || state_q == ST_FETCH2,
		state_q == ST_IDLE};
	wire logic [31:0] rd_mux =
		sel_dma ? {16'h0000, dma_control_q} :
		sel_lp1 ? {8'h00, list_pointer_one_q} :
		sel_lp2 ? {8'h00, list_pointer_two_q} :
		sel_cfg ? {30'h00000000, beam_cfg_q} :
		sel_sts ? {pc_q, 4'h0, status_bits} :
		sel_pos ? {14'h0000, beam_v, beam_h} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_q <= 32'h00000000;
		else if (psel && !penable)
			prdata_q <= rd_mux;
	end

	assign prdata = prdata_q;
	assign mem_req = req_q;
	assign mem_addr = addr_q;
	assign move_valid = mv_q;
	assign move_addr = mv_addr_q;
	assign move_data = mv_data_q;
	assign vblank = vbl_pulse;

endmodule

`default_nettype wire

// file: sim/dlcop_monitor.sv
/*
 * Checker for the coprocessor top: jump, fetch, move and wait timing.
 * Assumes it is bound to dlcop_top and sees only that module's ports.
 */
`timescale 1ns/100ps
`default_nettype none
module dlcop_monitor
	import dlcop_pkg::*;
(
	// Clock, reset and APB
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [31:0]        pwdata,
	// Fetch and moves
	input wire logic               mem_req,
	input wire logic [ADDR_W-1:0]  mem_addr,
	input wire logic [15:0]        mem_rdata,
	input wire logic               mem_ack,
	input wire logic               move_valid,
	input wire logic [8:0]         move_addr,
	input wire logic [15:0]        move_data,
	input wire logic               blit_done
);
	logic              dma_en_q, jp_q, req_q, wsel_q;
	logic [ADDR_W-1:0] ptr1_q, ptr2_q, tgt_q;
	logic [15:0]       w1_q, w2_q;
	wire               acc = psel & penable;
	wire               wr = acc & pwrite;
	wire               ack = mem_req & mem_ack;
	wire               req_new = mem_req & ~req_q;
	wire               strobe = acc & (paddr == OFF_JUMP1 | paddr == OFF_JUMP2);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_en_q <= 1'h0;
			jp_q     <= 1'h0;
			req_q    <= 1'h0;
			wsel_q   <= 1'h0;
		end else begin
			if (wr && paddr == OFF_DMA_CONTROL)
				dma_en_q <= pwdata[DMA_EN_BIT];
			jp_q   <= strobe | (jp_q & ~req_new);
			req_q  <= mem_req;
			wsel_q <= wsel_q ^ ack;
		end
	end

	// Shadows need no reset: each is written before it is looked at
	always_ff @(posedge pclk) begin
		if (wr && paddr == OFF_LIST_PTR1)
			ptr1_q <= {pwdata[ADDR_W-1:1], 1'h0};
		if (wr && paddr == OFF_LIST_PTR2)
			ptr2_q <= {pwdata[ADDR_W-1:1], 1'h0};
		if (strobe)
			tgt_q <= (paddr == OFF_JUMP2) ? ptr2_q : ptr1_q;
		if (ack && !wsel_q)
			w1_q <= mem_rdata;
		if (ack && wsel_q)
			w2_q <= mem_rdata;
	end

	chk_jump_target: assert property (
		jp_q && req_new |-> mem_addr == tgt_q)
		else $error("fetch after jump at wrong address");
	chk_dma_gate: assert property (
		!dma_en_q && !mem_req |=> !mem_req)
		else $error("fetch started with DMA off");
	chk_req_hold: assert property (
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("fetch request dropped or moved");
	chk_req_drop: assert property (
		ack |=> !mem_req)
		else $error("fetch request held past ack");
	chk_move_issue: assert property (
		ack && wsel_q && !w1_q[0] && dma_en_q && !jp_q |=> ##1 move_valid)
		else $error("move not issued");
	chk_move_kind: assert property (
		move_valid |-> !w1_q[0] && move_addr == {w1_q[8:1], 1'h0}
			&& move_data == w2_q)
		else $error("move fields wrong");
	chk_move_pulse: assert property (
		move_valid |=> !move_valid)
		else $error("move pulse too long");
	chk_wait_blit: assert property (
		!wsel_q && w1_q[0] && !w2_q[0] && !w2_q[15] && !blit_done
			&& !mem_req |=> !mem_req)
		else $error("wait left before blitter done");
endmodule

bind dlcop_top dlcop_monitor i_mon (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
	.mem_ack(mem_ack), .move_valid(move_valid), .move_addr(move_addr),
	.move_data(move_data), .blit_done(blit_done)
);
`default_nettype wire

// file: sim/dlcop_mem.sv
/*
 * List memory model: answers a held fetch with a one-cycle ack.
 * Assumes the bench fills the array by hierarchical writes.
 */
`timescale 1ns/100ps
`default_nettype none
module dlcop_mem
	import dlcop_pkg::*;
(
	// Clock, reset and pacing
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              slow,
	// Fetch port
	input  wire logic              mem_req,
	input  wire logic [ADDR_W-1:0] mem_addr,
	output logic      [15:0]       mem_rdata,
	output logic                   mem_ack
);
	logic [15:0] mem [0:1023];
	logic [1:0]  wait_q;
	wire         go = mem_req & ~mem_ack & (~slow | wait_q == 2'h3);

	// Data toggles off the ack cycle so a late sample is caught
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack   <= 1'h0;
			mem_rdata <= 16'h5A5A;
			wait_q    <= 2'h0;
		end else begin
			mem_ack   <= go;
			mem_rdata <= go ? mem[mem_addr[10:1]] : ~mem_rdata;
			wait_q    <= (mem_req & ~mem_ack & ~go) ? wait_q + 2'h1 : 2'h0;
		end
	end
endmodule
`default_nettype wire

// file: sim/test_display_list_coprocessor.sv
/*
 * Bench for the coprocessor: registers, jumps, moves, skip, wait, beam.
 * Assumes dlcop_mem as list memory and the bound checker.
 */
`timescale 1ns/100ps
`default_nettype none
module test_display_list_coprocessor;
	import dlcop_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        mem_req, mem_ack, move_valid, blit_done, vblank, slow, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] mem_addr;
	logic [15:0] mem_rdata, move_data;
	logic [8:0]  move_addr;
	logic [24:0] moves[$];
	int          errors, comparisons, vbl_seen;

	dlcop_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack), .move_valid(move_valid), .move_addr(move_addr),
		.move_data(move_data), .blit_done(blit_done), .vblank(vblank));
	dlcop_mem i_mem (.pclk(pclk), .presetn(presetn), .slow(slow),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack));

	initial begin
		pclk = 1'h0;
		forever #4 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (move_valid === 1'h1)
			moves.push_back({move_addr, move_data});
		if (vblank === 1'h1)
			vbl_seen++;
	end

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Only the watchdog ends a wait for pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task put(input int a, input logic [15:0] w1, input logic [15:0] w2);
		i_mem.mem[a / 2] = w1;
		i_mem.mem[a / 2 + 1] = w2;
	endtask

	task wait_moves(input int n, input int lim);
		for (int i = 0; i < lim && moves.size() < n; i++)
			@(posedge pclk);
	endtask

	task t_regs;
		apb(1'h0, OFF_DMA_CONTROL, 32'h0);
		chk("dma_control reset", 32'h0, rd);
		apb(1'h1, OFF_BEAM_CFG, 32'h3);
		apb(1'h0, OFF_BEAM_CFG, 32'h0);
		chk("beam config", 32'h3, rd);
		apb(1'h1, OFF_BEAM_CFG, 32'h0);
		apb(1'h1, OFF_LIST_PTR2, 32'h00FFFFFF);
		apb(1'h0, OFF_LIST_PTR2, 32'h0);
		chk("list_pointer_two", 32'h00FFFFFE, rd);
		apb(1'h0, 8'h40, 32'h0);
		chk("unmapped error", 32'h1, err);
		$display("t_regs done");
	endtask

	task t_start;
		put(256, 16'h009C, 16'h8010);
		put(260, 16'hFFFF, 16'hFFFE);
		apb(1'h1, OFF_LIST_PTR1, 32'h100);
		apb(1'h1, OFF_JUMP1, 32'h0);
		repeat (40) @(posedge pclk);
		chk("moves while disabled", 32'h0, moves.size());
		apb(1'h1, OFF_DMA_CONTROL, 32'h80);
		wait_moves(1, 200);
		repeat (100) @(posedge pclk);
		chk("moves after end wait", 32'h1, moves.size());
		chk("irq move", {9'h09C, 16'h8010}, moves.pop_front());
		$display("t_start done");
	endtask

	task t_skip;
		put(512, 16'h0001, 16'h0001);
		put(516, 16'h0180, 16'h1111);
		put(520, 16'h0182, 16'h2222);
		put(524, 16'hFF01, 16'h0001);
		put(528, 16'h0184, 16'h3333);
		put(532, 16'hFFFF, 16'hFFFE);
		slow <= 1'h1;
		apb(1'h1, OFF_LIST_PTR2, 32'h200);
		apb(1'h1, OFF_JUMP2, 32'h0);
		wait_moves(2, 600);
		repeat (100) @(posedge pclk);
		slow <= 1'h0;
		chk("skip move count", 32'h2, moves.size());
		chk("move after skip", {9'h182, 16'h2222}, moves.pop_front());
		chk("top bit compare", {9'h184, 16'h3333}, moves.pop_front());
		$display("t_skip done");
	endtask

	task t_blit;
		put(768, 16'h0001, 16'h0000);
		put(772, 16'h0186, 16'h4444);
		put(776, 16'hFFFF, 16'hFFFE);
		apb(1'h1, OFF_LIST_PTR1, 32'h300);
		apb(1'h0, OFF_JUMP1, 32'h0);
		repeat (60) @(posedge pclk);
		chk("move before blit done", 32'h0, moves.size());
		blit_done <= 1'h1;
		wait_moves(1, 100);
		chk("blit wait move", {9'h186, 16'h4444}, moves.pop_front());
		$display("t_blit done");
	endtask

	task t_wait_pos;
		logic [7:0] tv;
		apb(1'h0, OFF_BEAM_POS, 32'h0);
		tv = rd[15:8] + 8'h02;
		put(1024, {tv, 8'h01}, 16'hFF00);
		put(1028, 16'h0188, 16'h5555);
		put(1032, 16'hFFFF, 16'hFFFE);
		apb(1'h1, OFF_LIST_PTR1, 32'h400);
		apb(1'h1, OFF_JUMP1, 32'h0);
		for (int i = 0; i < 1500 && rd[15:8] < tv; i++) begin
			apb(1'h0, OFF_BEAM_POS, 32'h0);
			if (rd[15:8] < tv)
				chk("early wait move", 32'h0, moves.size());
		end
		wait_moves(1, 100);
		chk("wait move", {9'h188, 16'h5555}, moves.pop_front());
		// Pointer one goes back to the start list before any field wrap
		apb(1'h1, OFF_LIST_PTR1, 32'h100);
		$display("t_wait_pos done");
	endtask

	task t_beam;
		logic [7:0] mx;
		mx = 8'h00;
		// Longer than one line so the last position is always sampled
		for (int i = 0; i < 320; i++) begin
			apb(1'h0, OFF_BEAM_POS, 32'h0);
			if (rd[7:0] > mx)
				mx = rd[7:0];
			if (rd[7:0] > 8'hE2 || rd[17:8] >= 10'h106)
				chk("beam range", 32'h0, rd);
		end
		chk("last hpos", 32'hE2, mx);
		// The run is far shorter than one field, so no wrap may show
		chk("vblank before field end", 32'h0, vbl_seen);
		$display("t_beam done");
	endtask

	task results;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Whole run needs under 10000 cycles
	initial begin
		repeat (30000) @(posedge pclk);
		errors++;
		$display("watchdog expired");
		results;
	end

	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		blit_done = 1'h0;
		slow = 1'h0;
		errors = 0;
		comparisons = 0;
		vbl_seen = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		t_regs;
		t_start;
		t_skip;
		t_blit;
		t_wait_pos;
		t_beam;
		results;
	end
endmodule
`default_nettype wire
